// [hdl/seq_pkg.sv]
// constants, opcodes and types shared by the instruction sequencer and its alu
package seq_pkg;
  localparam int          INSTR_W      = 16;
  localparam int          DATA_W       = 8;
  localparam int          PHASES       = 4;
  localparam logic [1:0]  PHASE_FETCH  = 2'h1;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;
  localparam logic [7:0]  PC_LO_ADDR   = 8'h02;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [15:0] IR_RST       = 16'h0000;
  localparam logic [7:0]  MISC_NOP     = 8'h00;
  localparam logic [7:0]  MISC_HALT    = 8'h01;
  localparam logic [7:0]  MISC_CLRWDT  = 8'h02;

  // opcode field is instruction bits 15:11
  localparam logic [4:0] OP_ADD   = 5'h00;
  localparam logic [4:0] OP_ADC   = 5'h01;
  localparam logic [4:0] OP_SUB   = 5'h02;
  localparam logic [4:0] OP_SBC   = 5'h03;
  localparam logic [4:0] OP_AND   = 5'h04;
  localparam logic [4:0] OP_OR    = 5'h05;
  localparam logic [4:0] OP_XOR   = 5'h06;
  localparam logic [4:0] OP_INV   = 5'h07;
  localparam logic [4:0] OP_INC   = 5'h08;
  localparam logic [4:0] OP_DECR  = 5'h09;
  localparam logic [4:0] OP_ROR   = 5'h0a;
  localparam logic [4:0] OP_ROL   = 5'h0b;
  localparam logic [4:0] OP_RORC  = 5'h0c;
  localparam logic [4:0] OP_ROLC  = 5'h0d;
  localparam logic [4:0] OP_MOV   = 5'h0e;
  localparam logic [4:0] OP_MOVMA = 5'h0f;
  localparam logic [4:0] OP_ADDI  = 5'h10;
  localparam logic [4:0] OP_SUBI  = 5'h11;
  localparam logic [4:0] OP_ANDI  = 5'h12;
  localparam logic [4:0] OP_ORI   = 5'h13;
  localparam logic [4:0] OP_XORI  = 5'h14;
  localparam logic [4:0] OP_MOVI  = 5'h15;
  localparam logic [4:0] OP_SETB  = 5'h16;
  localparam logic [4:0] OP_CLRB  = 5'h17;
  localparam logic [4:0] OP_SZ    = 5'h18;
  localparam logic [4:0] OP_SZB   = 5'h19;
  localparam logic [4:0] OP_SNZB  = 5'h1a;
  localparam logic [4:0] OP_JUMP  = 5'h1b;
  localparam logic [4:0] OP_CALL  = 5'h1c;
  localparam logic [4:0] OP_RTN   = 5'h1d;
  localparam logic [4:0] OP_TBLRD = 5'h1e;
  localparam logic [4:0] OP_MISC  = 5'h1f;

  typedef enum logic [1:0] {mode_run, mode_extra, mode_table, mode_halt} mode_t;
endpackage : seq_pkg

// [hdl/alu_if.sv]
// carrier between the sequencer and its data-path alu
`timescale 1ns/100ps
interface alu_if;
  logic [4:0] op;
  logic [7:0] a;
  logic [7:0] b;
  logic [2:0] bit_idx;
  logic       cin;
  logic [7:0] result;
  logic       cout;
  logic       zero;
  logic       sets_c;
  logic       sets_z;
  modport alu  (input op, a, b, bit_idx, cin, output result, cout, zero, sets_c, sets_z);
  modport core (output op, a, b, bit_idx, cin, input result, cout, zero, sets_c, sets_z);
endinterface : alu_if

// [hdl/seq_alu.sv]
// combinational 8-bit alu: arithmetic, logic, rotates and bit edits
`timescale 1ns/100ps
module seq_alu (
  alu_if.alu p
);
  logic [8:0] sum;

  always_comb begin
    sum      = 9'h000;
    p.result = p.b;
    p.cout   = p.cin;
    p.sets_c = 1'b0;
    p.sets_z = 1'b0;
    case (p.op)
      seq_pkg::OP_ADD, seq_pkg::OP_ADDI, seq_pkg::OP_ADC: begin
        sum      = {1'b0, p.a} + {1'b0, p.b} + {8'h00, p.op == seq_pkg::OP_ADC && p.cin};
        p.result = sum[7:0];
        p.cout   = sum[8]; // RL5
        p.sets_c = 1'b1;
        p.sets_z = 1'b1;
      end
      seq_pkg::OP_SUB, seq_pkg::OP_SUBI, seq_pkg::OP_SBC: begin
        sum      = {1'b0, p.a} - {1'b0, p.b} - {8'h00, p.op == seq_pkg::OP_SBC && p.cin};
        p.result = sum[7:0];
        p.cout   = sum[8]; // RL5
        p.sets_c = 1'b1;
        p.sets_z = 1'b1;
      end
      seq_pkg::OP_AND, seq_pkg::OP_ANDI: begin
        p.result = p.a & p.b;
        p.sets_z = 1'b1; // RL7
      end
      seq_pkg::OP_OR, seq_pkg::OP_ORI: begin
        p.result = p.a | p.b;
        p.sets_z = 1'b1; // RL7
      end
      seq_pkg::OP_XOR, seq_pkg::OP_XORI: begin
        p.result = p.a ^ p.b;
        p.sets_z = 1'b1; // RL7
      end
      seq_pkg::OP_INV: begin
        p.result = ~p.b;
        p.sets_z = 1'b1; // RL7
      end
      seq_pkg::OP_INC: begin
        p.result = p.b + 8'h01; // RL6
        p.sets_z = 1'b1;
      end
      seq_pkg::OP_DECR: begin
        p.result = p.b - 8'h01; // RL6
        p.sets_z = 1'b1;
      end
      seq_pkg::OP_ROR:  p.result = {p.b[0], p.b[7:1]}; // RL8
      seq_pkg::OP_ROL:  p.result = {p.b[6:0], p.b[7]}; // RL8
      seq_pkg::OP_RORC: begin
        p.result = {p.cin, p.b[7:1]}; // RL8
        p.cout   = p.b[0];
        p.sets_c = 1'b1;
      end
      seq_pkg::OP_ROLC: begin
        p.result = {p.b[6:0], p.cin}; // RL8
        p.cout   = p.b[7];
        p.sets_c = 1'b1;
      end
      seq_pkg::OP_SETB: p.result = p.b | (8'h01 << p.bit_idx);    // RL13
      seq_pkg::OP_CLRB: p.result = p.b & ~(8'h01 << p.bit_idx);   // RL13
      default:          p.result = p.b;
    endcase
    p.zero = p.result == 8'h00;
  end
endmodule : seq_alu

// [hdl/mcu_instruction_sequencer.sv]
// instruction sequencer for an 8-bit accumulator core with program and data memory ports
// What this block does
// RL1: branch, call, return, table read take two cycles
// RL2: one instruction cycle is four clocks
// RL3: writing program counter low byte adds cycle
// RL4: skip taken costs one extra cycle
// RL5: carry on sum overflow, borrow on underflow
// RL6: increment/decrement by one, to memory or accumulator
// RL7: logic results set zero flag when zero
// RL8: rotates move one bit, through-carry swaps carry
// RL9: accumulator always drives alu input a; result goes to accumulator or memory
// RL10: call pushes next address, return resumes there
// RL11: jump loads target, saves nothing
// RL12: conditional skip tests byte or bit
// RL13: bit set/clear edits only one bit
// RL14: table read copies program word to data
// RL15: halt enters power-down; watchdog clear instruction
// RL16: return from interrupt also sets interrupt enable
// RL17: extra cycle discards prefetch, changes nothing
`timescale 1ns/100ps
module mcu_instruction_sequencer #(
  parameter int PC_W        = 11,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                clock,
  input  wire logic                rst,
  output logic [PC_W-1:0]          pm_addr,
  input  wire logic [15:0]         pm_data,
  output logic [7:0]               dm_addr,
  output logic [7:0]               dm_wdata,
  output logic                     dm_we,
  input  wire logic [7:0]          dm_rdata,
  input  wire logic                wake,
  output logic [7:0]               accumulator,
  output logic                     carry_flag,
  output logic                     zero_flag,
  output logic                     global_interrupt_enable,
  output logic                     halted,
  output logic                     wdt_clear,
  output logic [7:0]               table_high,
  output logic                     cycle_start
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // address field of jump/call is 11 bits, and the low byte must fit below it
  if (PC_W < 9 || PC_W > 11 || STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_param
    $error("PC_W must be 9..11 and STACK_DEPTH a power of two >= 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [1:0]          phase;
  logic [1:0]          next_phase;
  seq_pkg::mode_t      mode;
  seq_pkg::mode_t      next_mode;
  logic [15:0]         ir;
  logic [15:0]         next_ir;
  logic [PC_W-1:0]     pc;
  logic [PC_W-1:0]     next_pc;
  logic [PC_W-1:0]     next_pm_addr;
  logic [7:0]          next_dm_addr;
  logic [7:0]          next_dm_wdata;
  logic                next_dm_we;
  logic [7:0]          next_accumulator;
  logic                next_carry_flag;
  logic                next_zero_flag;
  logic                next_global_interrupt_enable;
  logic                next_halted;
  logic                next_wdt_clear;
  logic [7:0]          next_table_high;
  logic                next_cycle_start;
  logic [SP_W-1:0]     sp;
  logic [SP_W-1:0]     next_sp;
  logic [PC_W-1:0]     stack [STACK_DEPTH];
  logic                stack_we;
  logic [PC_W-1:0]     stack_wdata;
  logic                wake_meta;
  logic                wake_sync;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  logic [4:0]          opcode;
  logic                dest_mem;
  logic [7:0]          mem_val;
  logic [PC_W-1:0]     pc_inc;
  logic [PC_W-1:0]     target;
  logic [PC_W-1:0]     table_addr;

  assign opcode     = ir[15:11];
  // reads of the low program counter byte see the live counter
  assign mem_val    = (ir[7:0] == seq_pkg::PC_LO_ADDR) ? pc[7:0] : dm_rdata;
  assign pc_inc     = pc + PC_W'(1);
  assign target     = ir[PC_W-1:0];
  // table sits in the current 256-word page, indexed by the accumulator
  assign table_addr = {pc[PC_W-1:8], accumulator};
  assign dest_mem   = (opcode <= seq_pkg::OP_ROLC && ir[10]) || opcode == seq_pkg::OP_MOVMA ||
                      opcode == seq_pkg::OP_SETB || opcode == seq_pkg::OP_CLRB;

  alu_if alu_bus ();

  assign alu_bus.op      = opcode;
  assign alu_bus.a       = accumulator; // RL9
  assign alu_bus.b       = (opcode >= seq_pkg::OP_ADDI && opcode <= seq_pkg::OP_MOVI) ? ir[7:0] :
                           (opcode == seq_pkg::OP_MOVMA) ? accumulator : mem_val;
  assign alu_bus.bit_idx = ir[10:8];
  assign alu_bus.cin     = carry_flag;

  seq_alu u_alu (
    .p (alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake;
      wake_sync <= wake_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and execution

  logic extra;
  logic skip;

  always_comb begin
    next_phase                   = phase + 2'h1; // RL2
    next_mode                    = mode;
    next_ir                      = ir;
    next_pc                      = pc;
    next_pm_addr                 = pm_addr;
    next_dm_addr                 = dm_addr;
    next_dm_wdata                = dm_wdata;
    next_dm_we                   = 1'b0;
    next_accumulator             = accumulator;
    next_carry_flag              = carry_flag;
    next_zero_flag               = zero_flag;
    next_global_interrupt_enable = global_interrupt_enable;
    next_halted                  = halted;
    next_wdt_clear               = 1'b0;
    next_table_high              = table_high;
    next_cycle_start             = phase == seq_pkg::PHASE_LAST;
    next_sp                      = sp;
    stack_we                     = 1'b0;
    stack_wdata                  = pc_inc;
    extra                        = 1'b0;
    skip                         = 1'b0;
    if (phase == seq_pkg::PHASE_FETCH) begin
      if (mode == seq_pkg::mode_run) begin
        next_ir      = pm_data;
        next_dm_addr = pm_data[7:0];
      end else if (mode == seq_pkg::mode_table) begin
        next_table_high = pm_data[15:8]; // RL14
        next_dm_wdata   = pm_data[7:0];
        next_dm_we      = 1'b1;
      end
    end else if (phase == seq_pkg::PHASE_LAST) begin
      case (mode)
        seq_pkg::mode_run: begin
          next_pc = pc_inc;
          if (opcode <= seq_pkg::OP_CLRB) begin
            if (alu_bus.sets_c) begin
              next_carry_flag = alu_bus.cout; // RL5 RL8
            end
            if (alu_bus.sets_z) begin
              next_zero_flag = alu_bus.zero; // RL7
            end
            if (!dest_mem) begin
              next_accumulator = alu_bus.result; // RL6 RL9
            end else if (ir[7:0] == seq_pkg::PC_LO_ADDR) begin
              next_pc = {pc[PC_W-1:8], alu_bus.result}; // RL3
              extra   = 1'b1;
            end else begin
              next_dm_wdata = alu_bus.result; // RL13
              next_dm_we    = 1'b1;
            end
          end else begin
            case (opcode)
              seq_pkg::OP_SZ:   skip = (mem_val == 8'h00) ^ ir[10]; // RL12
              seq_pkg::OP_SZB:  skip = !mem_val[ir[10:8]];          // RL12
              seq_pkg::OP_SNZB: skip = mem_val[ir[10:8]];           // RL12
              seq_pkg::OP_JUMP: begin
                next_pc = target; // RL11
                extra   = 1'b1;   // RL1
              end
              seq_pkg::OP_CALL: begin
                stack_we = 1'b1; // RL10
                next_sp  = sp + SP_W'(1);
                next_pc  = target;
                extra    = 1'b1; // RL1
              end
              seq_pkg::OP_RTN: begin
                next_sp = sp - SP_W'(1);
                next_pc = stack[sp - SP_W'(1)]; // RL10
                extra   = 1'b1;                 // RL1
                if (ir[10]) begin
                  next_global_interrupt_enable = 1'b1; // RL16
                end
              end
              seq_pkg::OP_TBLRD: next_mode = seq_pkg::mode_table; // RL1 RL14
              seq_pkg::OP_MISC: begin
                if (ir[7:0] == seq_pkg::MISC_HALT) begin
                  next_mode   = seq_pkg::mode_halt; // RL15
                  next_halted = 1'b1;
                end else if (ir[7:0] == seq_pkg::MISC_CLRWDT) begin
                  next_wdt_clear = 1'b1; // RL15
                end
              end
              default: next_pc = pc_inc;
            endcase
          end
          if (skip) begin
            next_pc = pc + PC_W'(2); // RL4
            extra   = 1'b1;
          end
          if (extra) begin
            next_mode = seq_pkg::mode_extra;
          end
          next_pm_addr = (opcode == seq_pkg::OP_TBLRD) ? table_addr : next_pc;
        end
        seq_pkg::mode_extra: begin
          next_mode = seq_pkg::mode_run; // RL17
        end
        seq_pkg::mode_table: begin
          next_mode    = seq_pkg::mode_run;
          next_pm_addr = pc;
        end
        seq_pkg::mode_halt: begin
          if (wake_sync) begin
            next_mode   = seq_pkg::mode_run; // RL15
            next_halted = 1'b0;
          end
        end
        default: next_mode = seq_pkg::mode_run;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase                   <= 2'h0;
      mode                    <= seq_pkg::mode_run;
      ir                      <= seq_pkg::IR_RST;
      pc                      <= '0;
      pm_addr                 <= '0;
      dm_addr                 <= 8'h00;
      dm_wdata                <= 8'h00;
      dm_we                   <= 1'b0;
      accumulator             <= seq_pkg::ACC_RST;
      carry_flag              <= 1'b0;
      zero_flag               <= 1'b0;
      global_interrupt_enable <= 1'b0;
      halted                  <= 1'b0;
      wdt_clear               <= 1'b0;
      table_high              <= 8'h00;
      cycle_start             <= 1'b0;
      sp                      <= '0;
    end else begin
      phase                   <= next_phase;
      mode                    <= next_mode;
      ir                      <= next_ir;
      pc                      <= next_pc;
      pm_addr                 <= next_pm_addr;
      dm_addr                 <= next_dm_addr;
      dm_wdata                <= next_dm_wdata;
      dm_we                   <= next_dm_we;
      accumulator             <= next_accumulator;
      carry_flag              <= next_carry_flag;
      zero_flag               <= next_zero_flag;
      global_interrupt_enable <= next_global_interrupt_enable;
      halted                  <= next_halted;
      wdt_clear               <= next_wdt_clear;
      table_high              <= next_table_high;
      cycle_start             <= next_cycle_start;
      sp                      <= next_sp;
    end
  end

  // stack is plain storage; no reset so it maps to a small ram
  always_ff @(posedge clock) begin
    if (stack_we && !rst) begin
      stack[sp] <= stack_wdata;
    end
  end
endmodule : mcu_instruction_sequencer

// [verif/mcu_instruction_sequencer_chk.sv]
// port-level timing checks for the instruction sequencer
`timescale 1ns/100ps
module mcu_instruction_sequencer_chk #(
  parameter int PC_W = 11
) (
  input wire logic            clock,
  input wire logic            rst,
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic [15:0]     pm_data,
  input wire logic [7:0]      dm_addr,
  input wire logic [7:0]      dm_wdata,
  input wire logic            dm_we,
  input wire logic [7:0]      dm_rdata,
  input wire logic            wake,
  input wire logic [7:0]      accumulator,
  input wire logic            carry_flag,
  input wire logic            zero_flag,
  input wire logic            global_interrupt_enable,
  input wire logic            halted,
  input wire logic            wdt_clear,
  input wire logic [7:0]      table_high,
  input wire logic            cycle_start
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  start_period_a: assert property (cycle_start |=> !cycle_start [*3] ##1 (cycle_start || halted))
    else $error("cycle start pulses are not four clocks apart");
  pm_addr_slot_a: assert property (!$stable(pm_addr) |-> cycle_start)
    else $error("program address moved off a cycle boundary");
  state_slot_a: assert property (!$stable({accumulator, carry_flag, zero_flag}) |-> cycle_start)
    else $error("accumulator or flags changed inside a cycle");
  dm_write_slot_a: assert property (dm_we |-> (cycle_start || $past(cycle_start, 2)) ##1 !dm_we)
    else $error("data write strobe outside its slot");
  table_slot_a: assert property (!$stable(table_high) |-> $past(cycle_start, 2))
    else $error("table high byte changed outside the extra cycle");
  wdt_pulse_a: assert property (wdt_clear |-> cycle_start ##1 !wdt_clear)
    else $error("watchdog clear pulse misplaced");
  halt_entry_a: assert property ($rose(halted) |-> cycle_start)
    else $error("halt entered off a cycle boundary");
  halt_hold_a: assert property (halted && !wake && !$past(wake) && !$past(wake, 2) |=> halted)
    else $error("halt left without wake");
  gie_rise_a: assert property ($rose(global_interrupt_enable) |-> cycle_start)
    else $error("interrupt enable set off a cycle boundary");
  gie_hold_a: assert property (global_interrupt_enable |=> global_interrupt_enable)
    else $error("interrupt enable cleared without reset");

  cover property (dm_we && cycle_start);
  cover property ($rose(global_interrupt_enable));
  cover property ($fell(halted));
endmodule : mcu_instruction_sequencer_chk

bind mcu_instruction_sequencer mcu_instruction_sequencer_chk #(.PC_W(PC_W)) chk_inst (
  .clock(clock), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
  .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata), .wake(wake), .accumulator(accumulator),
  .carry_flag(carry_flag), .zero_flag(zero_flag), .global_interrupt_enable(global_interrupt_enable),
  .halted(halted), .wdt_clear(wdt_clear), .table_high(table_high), .cycle_start(cycle_start)
);

// [verif/mcu_instruction_sequencer_bench.sv]
// self-checking bench: small programs run against modelled program and data memories
`timescale 1ns/100ps
module mcu_instruction_sequencer_bench;
  logic        clock;
  logic        rst;
  logic [10:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0]  dm_addr;
  logic [7:0]  dm_wdata;
  logic        dm_we;
  logic [7:0]  dm_rdata;
  logic        wake;
  logic [7:0]  accumulator;
  logic        carry_flag;
  logic        zero_flag;
  logic        global_interrupt_enable;
  logic        halted;
  logic        wdt_clear;
  logic [7:0]  table_high;
  logic        cycle_start;
  logic [15:0] prog [0:2047];
  logic [7:0]  dmem [0:255];
  int          miscompares;
  int          n_compared;
  int          starts;
  int          wdt_pulses;

  `define check(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end

  mcu_instruction_sequencer #(.PC_W(11), .STACK_DEPTH(8)) mcu_instruction_sequencer_inst (
    .clock(clock), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata), .wake(wake), .accumulator(accumulator),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .global_interrupt_enable(global_interrupt_enable),
    .halted(halted), .wdt_clear(wdt_clear), .table_high(table_high), .cycle_start(cycle_start)
  );

  initial clock = 1'b0;
  always #25 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // both memories answer one clock after the address, as the core expects
  always @(posedge clock) begin
    pm_data  <= prog[pm_addr];
    dm_rdata <= dmem[dm_addr];
    if (dm_we === 1'b1) dmem[dm_addr] <= dm_wdata;
    if (rst) begin
      starts     <= 0;
      wdt_pulses <= 0;
    end else begin
      if (cycle_start === 1'b1 && halted !== 1'b1) starts <= starts + 1;
      if (wdt_clear === 1'b1) wdt_pulses <= wdt_pulses + 1;
    end
  end

  task automatic p(input int a, input logic [4:0] op, input logic [2:0] x, input logic [7:0] m);
    prog[a] = {op, x, m};
  endtask : p

  task automatic begin_prog;
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 2048; i++) prog[i] = 16'hf800;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
  endtask : begin_prog

  task automatic wait_halt(input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (halted !== lvl && n < lim);
    `check("halted", lvl, halted)
  endtask : wait_halt

  // every program ends in halt; the count of cycle starts before it fixes the cycle budget
  task automatic run(input int exp_starts);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    wait_halt(1'b1, 400);
    `check("cycle_starts", exp_starts, starts)
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  task automatic arith_test;
    begin_prog();
    dmem[8'h40] = 8'h05;
    p(0, seq_pkg::OP_MOVI, 3'h0, 8'h03);
    p(1, seq_pkg::OP_SUB, 3'h4, 8'h40);
    p(2, seq_pkg::OP_SBC, 3'h0, 8'h40);
    p(3, seq_pkg::OP_MOVMA, 3'h0, 8'h30);
    p(4, seq_pkg::OP_ADDI, 3'h0, 8'hfc);
    p(5, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    run(5);
    `check("dm40", 8'hfe, dmem[8'h40])
    `check("dm30", 8'h04, dmem[8'h30])
    `check("acc", 8'h00, accumulator)
    `check("carry", 1'b1, carry_flag)
    `check("zero", 1'b1, zero_flag)
  endtask : arith_test

  task automatic logic_test;
    begin_prog();
    dmem[8'h41] = 8'h0f;
    dmem[8'h42] = 8'h81;
    dmem[8'h43] = 8'h01;
    dmem[8'h44] = 8'h80;
    dmem[8'h45] = 8'hff;
    dmem[8'h46] = 8'h01;
    p(0, seq_pkg::OP_MOVI, 3'h0, 8'hf0);
    p(1, seq_pkg::OP_AND, 3'h0, 8'h41);
    p(2, seq_pkg::OP_INC, 3'h4, 8'h41);
    p(3, seq_pkg::OP_INV, 3'h0, 8'h45);
    p(4, seq_pkg::OP_RORC, 3'h0, 8'h42);
    p(5, seq_pkg::OP_ROLC, 3'h4, 8'h42);
    p(6, seq_pkg::OP_ROR, 3'h0, 8'h43);
    p(7, seq_pkg::OP_ROL, 3'h4, 8'h44);
    p(8, seq_pkg::OP_DECR, 3'h4, 8'h46);
    p(9, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    run(9);
    `check("dm41", 8'h10, dmem[8'h41])
    `check("dm42", 8'h03, dmem[8'h42])
    `check("dm44", 8'h01, dmem[8'h44])
    `check("dm46", 8'h00, dmem[8'h46])
    `check("acc", 8'h80, accumulator)
    `check("carry", 1'b1, carry_flag)
    `check("zero", 1'b1, zero_flag)
  endtask : logic_test

  // a taken skip costs its extra cycle, a failed test does not
  task automatic bit_test;
    begin_prog();
    dmem[8'h50] = 8'h5a;
    p(0, seq_pkg::OP_SETB, 3'h0, 8'h50);
    p(1, seq_pkg::OP_CLRB, 3'h6, 8'h50);
    p(2, seq_pkg::OP_SZB, 3'h2, 8'h50);
    p(3, seq_pkg::OP_MOVI, 3'h0, 8'hee);
    p(4, seq_pkg::OP_SNZB, 3'h7, 8'h50);
    p(5, seq_pkg::OP_MOVI, 3'h0, 8'h11);
    p(6, seq_pkg::OP_SZ, 3'h0, 8'h51);
    p(7, seq_pkg::OP_MOVI, 3'h0, 8'h22);
    p(8, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    run(8);
    `check("dm50", 8'h1b, dmem[8'h50])
    `check("acc", 8'h11, accumulator)
  endtask : bit_test

  task automatic branch_test;
    begin_prog();
    p(0, seq_pkg::OP_CALL, 3'h0, 8'h08);
    p(1, seq_pkg::OP_JUMP, 3'h0, 8'h04);
    p(2, seq_pkg::OP_MOVI, 3'h0, 8'hbb);
    p(3, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    p(4, seq_pkg::OP_MOVI, 3'h0, 8'h07);
    p(5, seq_pkg::OP_MOVMA, 3'h0, seq_pkg::PC_LO_ADDR);
    p(6, seq_pkg::OP_MOVI, 3'h0, 8'hbb);
    p(7, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    p(8, seq_pkg::OP_MOVI, 3'h0, 8'h77);
    p(9, seq_pkg::OP_RTN, 3'h4, 8'h00);
    run(10);
    `check("acc", 8'h07, accumulator)
    `check("gie", 1'b1, global_interrupt_enable)
    `check("dm02", 8'h00, dmem[seq_pkg::PC_LO_ADDR])
  endtask : branch_test

  task automatic table_test;
    begin_prog();
    prog[11'h080] = 16'ha55a;
    p(0, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_CLRWDT);
    p(1, seq_pkg::OP_MOVI, 3'h0, 8'h80);
    p(2, seq_pkg::OP_TBLRD, 3'h0, 8'h60);
    p(3, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    p(4, seq_pkg::OP_MOVI, 3'h0, 8'h44);
    p(5, seq_pkg::OP_MISC, 3'h0, seq_pkg::MISC_HALT);
    run(4);
    `check("dm60", 8'h5a, dmem[8'h60])
    `check("table_high", 8'ha5, table_high)
    `check("wdt_pulses", 1, wdt_pulses)
    repeat (12) @(posedge clock);
    `check("halted", 1'b1, halted)
    @(posedge clock);
    wake <= 1'b1;
    wait_halt(1'b0, 20);
    @(posedge clock);
    wake <= 1'b0;
    wait_halt(1'b1, 40);
    `check("acc", 8'h44, accumulator)
  endtask : table_test

  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wake = 1'b0;
    miscompares = 0;
    n_compared = 0;
    arith_test();
    logic_test();
    bit_test();
    branch_test();
    table_test();
    final_report();
  end

  // the five programs need well under a thousand clocks
  initial begin
    #(50 * 3000);
    miscompares++;
    final_report();
  end
endmodule : mcu_instruction_sequencer_bench
